// ---- src/rail_ctrl.v ----
// Purpose: two-rail enable, good and setpoint control
// Assumes: one clock, synchronous inputs, plain register port
// Notes: good pins are open drain, enable high pulls low
`timescale 1ns/10ps
`include "rail_ctrl_consts.vh"
module rail_ctrl (
  input wire clk,
  input wire srst,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire bus_control_pin,
  input wire [1:0] rail_enable_pin,
  input wire [1:0] ramping,
  input wire [1:0] light_load,
  input wire [1:0] rail_in_window,
  input wire signed [11:0] sense_positive_1,
  input wire signed [11:0] sense_negative_1,
  input wire signed [11:0] sense_positive_2,
  input wire signed [11:0] sense_negative_2,
  output reg [1:0] rail_on,
  output reg [1:0] fault_suppress,
  output reg [1:0] rail_good_indicator_oe,
  output reg [1:0] rail_good_indicator_out,
  output reg all_rails_good_oe,
  output reg all_rails_good_out,
  output reg [11:0] err_codes,
  output reg [19:0] dac_values
);
  reg [6:0] on_off;
  reg [15:0] operation;
  reg [1:0] vid_setup;
  reg [9:0] vout_nom [0:1];
  reg [9:0] vout_high [0:1];
  reg [9:0] vout_low [0:1];
  reg [9:0] vout_vid [0:1];
  reg [11:0] gain_banks;
  reg [7:0] sample_point;
  reg [1:0] good_mask;
  reg [1:0] next_on;
  reg [9:0] setpoint [0:1];
  reg [1:0] gain_sel [0:1];
  reg [1:0] good;
  wire [9:0] dac_1;
  wire [9:0] dac_2;
  wire signed [5:0] err_1;
  wire signed [5:0] err_2;
  wire [1:0] sat;
  wire [1:0] strobe;
  wire pin_active;
  wire [1:0] en_active;
  integer i;
  integer j;

  assign pin_active = bus_control_pin ^ ~on_off[`ONOFF_POL_BIT];
  assign en_active = rail_enable_pin ^ {2{~on_off[`ONOFF_POL_BIT]}};

  always @* begin
    for (i = 0; i < 2; i = i + 1) begin
      case (on_off[i*3 +: 3])
        `ONOFF_OFF: next_on[i] = 1'b0;
        `ONOFF_AUTO: next_on[i] = 1'b1;
        `ONOFF_PIN: next_on[i] = pin_active & en_active[i];
        `ONOFF_CMD: next_on[i] = operation[i*8 + `OP_RUN_BIT];
        `ONOFF_BOTH: next_on[i] = pin_active & en_active[i] &
                                  operation[i*8 + `OP_RUN_BIT];
        default: next_on[i] = 1'b0;
      endcase
      if (vid_setup[i]) begin
        setpoint[i] = vout_vid[i];
      end else begin
        case (operation[i*8 + `OP_SEL_LSB +: 2])
          `SEL_HIGH: setpoint[i] = vout_high[i];
          `SEL_LOW: setpoint[i] = vout_low[i];
          default: setpoint[i] = vout_nom[i];
        endcase
      end
      if (ramping[i])
        gain_sel[i] = gain_banks[i*6 +: 2];
      else if (light_load[i])
        gain_sel[i] = gain_banks[i*6 + 4 +: 2];
      else
        gain_sel[i] = gain_banks[i*6 + 2 +: 2];
      good[i] = rail_on[i] & rail_in_window[i] & ~sat[i] & good_mask[i];
    end
  end

  rail_loop u_rail_1 (
    .clk(clk),
    .srst(srst),
    .on(rail_on[0]),
    .setpoint(setpoint[0]),
    .gain_code(gain_sel[0]),
    .sample_point(sample_point),
    .sense_positive(sense_positive_1),
    .sense_negative(sense_negative_1),
    .dac(dac_1),
    .err_code(err_1),
    .saturated(sat[0]),
    .sample_strobe(strobe[0])
  );

  rail_loop u_rail_2 (
    .clk(clk),
    .srst(srst),
    .on(rail_on[1]),
    .setpoint(setpoint[1]),
    .gain_code(gain_sel[1]),
    .sample_point(sample_point),
    .sense_positive(sense_positive_2),
    .sense_negative(sense_negative_2),
    .dac(dac_2),
    .err_code(err_2),
    .saturated(sat[1]),
    .sample_strobe(strobe[1])
  );

  always @(posedge clk) begin
    if (srst) begin
      on_off <= `ONOFF_RESET;
      operation <= `OP_RESET;
      vid_setup <= 2'h0;
      vout_nom[0] <= `VOUT_RESET;
      vout_nom[1] <= `VOUT_RESET;
      vout_high[0] <= `VOUT_RESET;
      vout_high[1] <= `VOUT_RESET;
      vout_low[0] <= `VOUT_RESET;
      vout_low[1] <= `VOUT_RESET;
      vout_vid[0] <= `VOUT_RESET;
      vout_vid[1] <= `VOUT_RESET;
      gain_banks <= `GAIN_RESET;
      sample_point <= `SAMPLE_RESET;
      good_mask <= 2'h3;
    end else if (wr) begin
      case (addr)
        `REG_ON_OFF: on_off <= wdata[6:0];
        `REG_OPERATION: operation <= wdata[15:0];
        `REG_VID_SETUP: vid_setup <= wdata[1:0];
        `REG_VOUT_NOM: begin
          vout_nom[0] <= wdata[9:0];
          vout_nom[1] <= wdata[25:16];
        end
        `REG_VOUT_HIGH: begin
          vout_high[0] <= wdata[9:0];
          vout_high[1] <= wdata[25:16];
        end
        `REG_VOUT_LOW: begin
          vout_low[0] <= wdata[9:0];
          vout_low[1] <= wdata[25:16];
        end
        `REG_VOUT_VID: begin
          vout_vid[0] <= wdata[9:0];
          vout_vid[1] <= wdata[25:16];
        end
        `REG_GAIN_BANKS: gain_banks <= wdata[11:0];
        `REG_SAMPLE_POINT: sample_point <= wdata[7:0];
        `REG_GOOD_CTRL: good_mask <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk) begin
    if (srst || !rd) begin
      rdata <= 32'h00000000;
    end else begin
      case (addr)
        `REG_ON_OFF: rdata <= {25'h0, on_off};
        `REG_OPERATION: rdata <= {16'h0, operation};
        `REG_VID_SETUP: rdata <= {30'h0, vid_setup};
        `REG_VOUT_NOM: rdata <= {6'h0, vout_nom[1], 6'h0, vout_nom[0]};
        `REG_VOUT_HIGH: rdata <= {6'h0, vout_high[1], 6'h0, vout_high[0]};
        `REG_VOUT_LOW: rdata <= {6'h0, vout_low[1], 6'h0, vout_low[0]};
        `REG_VOUT_VID: rdata <= {6'h0, vout_vid[1], 6'h0, vout_vid[0]};
        `REG_GAIN_BANKS: rdata <= {20'h0, gain_banks};
        `REG_SAMPLE_POINT: rdata <= {24'h0, sample_point};
        `REG_GOOD_CTRL: rdata <= {30'h0, good_mask};
        `REG_STATUS: rdata <= {10'h000, err_2, err_1, 4'h0, sat,
                               rail_good_indicator_oe, rail_on};
        `REG_DAC_R1: rdata <= {22'h0, dac_1};
        `REG_DAC_R2: rdata <= {22'h0, dac_2};
        default: rdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      rail_on <= 2'h0;
      fault_suppress <= 2'h0;
      rail_good_indicator_oe <= 2'h3;
      rail_good_indicator_out <= 2'h0;
      all_rails_good_oe <= 1'b1;
      all_rails_good_out <= 1'b0;
      err_codes <= 12'h000;
      dac_values <= 20'h00000;
    end else begin
      rail_on <= next_on;
      for (j = 0; j < 2; j = j + 1)
        fault_suppress[j] <= operation[j*8 + `OP_SUPP_BIT] &
          (operation[j*8 + `OP_SEL_LSB +: 2] != `SEL_NOMINAL);
      rail_good_indicator_oe <= ~good;
      rail_good_indicator_out <= 2'h0;
      all_rails_good_oe <= ~(&good);
      all_rails_good_out <= 1'b0;
      err_codes <= {err_2, err_1};
      dac_values <= {dac_2, dac_1};
    end
  end
endmodule // rail_ctrl

// ---- src/rail_ctrl_consts.vh ----
// Purpose: constants for the two-rail enable and setpoint control block
// Assumes: 125 MHz core clock, 10-bit reference DAC
// Notes: offsets are word indices on the plain register port
`ifndef RAIL_CTRL_CONSTS_VH
`define RAIL_CTRL_CONSTS_VH

// register indices
`define REG_ON_OFF 4'h0
`define REG_OPERATION 4'h1
`define REG_VID_SETUP 4'h2
`define REG_VOUT_NOM 4'h3
`define REG_VOUT_HIGH 4'h4
`define REG_VOUT_LOW 4'h5
`define REG_VOUT_VID 4'h6
`define REG_GAIN_BANKS 4'h7
`define REG_SAMPLE_POINT 4'h8
`define REG_GOOD_CTRL 4'h9
`define REG_STATUS 4'hA
`define REG_DAC_R1 4'hB
`define REG_DAC_R2 4'hC

// on/off method codes, one 3-bit field per rail
`define ONOFF_OFF 3'h0
`define ONOFF_AUTO 3'h1
`define ONOFF_PIN 3'h2
`define ONOFF_CMD 3'h3
`define ONOFF_BOTH 3'h4
`define ONOFF_POL_BIT 6
`define ONOFF_RESET 7'h49

// run-state fields per rail byte: run, select[2:1], suppress[3]
`define OP_RUN_BIT 0
`define OP_SEL_LSB 1
`define OP_SUPP_BIT 3
`define SEL_NOMINAL 2'h0
`define SEL_HIGH 2'h1
`define SEL_LOW 2'h2
`define OP_RESET 16'h0000

// bank fields: ramp[1:0], regulate[3:2], light[5:4] per rail
`define GAIN_RESET 12'hAAA
`define BANK_RAMP 2'h0
`define BANK_REG 2'h1
`define BANK_LIGHT 2'h2

`define DAC_MAX 10'h3FF
`define VOUT_RESET 10'h000
`define SAMPLE_RESET 8'h40
`define PERIOD_CYCLES 8'hFA

// error converter clamp
`define ERR_MAX 6'sh1F
`define ERR_MIN 6'sh20

// slew: 0.156 V/ms; one 1 mV DAC step every 6.41 us
`define CLK_MHZ 125
`define SLEW_UV_PER_MS 156
`define SLEW_STEP_CYCLES ((`CLK_MHZ * 1000000) / (`SLEW_UV_PER_MS * 1000))

`endif

// ---- src/slew_timer.v ----
// Purpose: periodic tick for reference slewing
// Assumes: synchronous reset
// Notes: runs only while enabled, restarts on release
`timescale 1ns/10ps
module slew_timer #(
  parameter PERIOD = 801
) (
  input wire clk,
  input wire srst,
  input wire run,
  output reg tick
);
  reg [15:0] count;

  always @(posedge clk) begin
    if (srst || !run) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count == PERIOD[15:0] - 16'h0001) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // slew_timer

// ---- src/rail_loop.v ----
// Purpose: one rail's error path: sample, subtract, gain, clamp, slew
// Assumes: sense inputs are signed mV codes synchronous to clk
// Notes: reference is a 10-bit DAC in 1 mV units
`timescale 1ns/10ps
`include "rail_ctrl_consts.vh"
module rail_loop (
  input wire clk,
  input wire srst,
  input wire on,
  input wire [9:0] setpoint,
  input wire [1:0] gain_code,
  input wire [7:0] sample_point,
  input wire signed [11:0] sense_positive,
  input wire signed [11:0] sense_negative,
  output reg [9:0] dac,
  output reg signed [5:0] err_code,
  output reg saturated,
  output reg sample_strobe
);
  reg [7:0] phase;
  reg signed [12:0] sampled;
  reg signed [13:0] diff;
  reg signed [13:0] scaled;
  wire tick;

  slew_timer #(.PERIOD(`SLEW_STEP_CYCLES)) u_tick (
    .clk(clk),
    .srst(srst),
    .run(saturated),
    .tick(tick)
  );

  // scaled error in LSBs: 8,4,2,1 mV per LSB for codes 0..3
  always @* begin
    diff = {{4{1'b0}}, dac} - {sampled[12], sampled};
    case (gain_code)
      2'h0: scaled = diff >>> 3;
      2'h1: scaled = diff >>> 2;
      2'h2: scaled = diff >>> 1;
      default: scaled = diff;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      phase <= 8'h00;
      sampled <= 13'sh0000;
      err_code <= 6'sh00;
      saturated <= 1'b0;
      sample_strobe <= 1'b0;
      dac <= `VOUT_RESET;
    end else begin
      phase <= (phase == `PERIOD_CYCLES - 8'h01) ? 8'h00 : phase + 8'h01;
      sample_strobe <= (phase == sample_point);
      if (phase == sample_point) begin
        sampled <= {sense_positive[11], sense_positive} -
                   {sense_negative[11], sense_negative};
      end
      if (scaled > 14'sd31) begin
        err_code <= `ERR_MAX;
        saturated <= 1'b1;
      end else if (scaled < -14'sd32) begin
        err_code <= `ERR_MIN;
        saturated <= 1'b1;
      end else begin
        err_code <= scaled[5:0];
        saturated <= 1'b0;
      end
      if (!on) begin
        dac <= setpoint;
      end else if (saturated) begin
        if (tick && err_code[5] && dac != `DAC_MAX)
          dac <= dac + 10'h001;
        else if (tick && !err_code[5] && dac != 10'h000)
          dac <= dac - 10'h001;
      end else begin
        dac <= setpoint;
      end
    end
  end
endmodule // rail_loop

// ---- tb/rail_ctrl_properties.sv ----
// Purpose: port checks for the rail enable and setpoint block
// Assumes: one clock, srst synchronous active high
// Notes: slew spacing checked on rail 1 only
`timescale 1ns/10ps
module rail_ctrl_properties (
  input wire clk,
  input wire srst,
  input wire rd,
  input wire [31:0] rdata,
  input wire [1:0] rail_on,
  input wire [1:0] rail_good_indicator_oe,
  input wire [1:0] rail_good_indicator_out,
  input wire all_rails_good_oe,
  input wire all_rails_good_out,
  input wire [11:0] err_codes,
  input wire [19:0] dac_values
);
  localparam int STEP_GAP = 800;
  logic [11:0] gap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // edges since the rail 1 reference last moved
  always @(posedge clk) begin
    if (srst || $changed(dac_values[9:0]))
      gap <= 12'h000;
    else if (gap != 12'hFFF)
      gap <= gap + 12'h001;
  end
  sequence sat_low;
    err_codes[5:0] == 6'h20 ##1 err_codes[5:0] == 6'h20;
  endsequence
  a_good_never_high: assert property (
    rail_good_indicator_out == 2'h0 && !all_rails_good_out)
    else $error("good output driven high");
  a_all_good_and: assert property (
    !all_rails_good_oe |-> rail_good_indicator_oe == 2'h0)
    else $error("combined good released alone");
  a_good_needs_on: assert property (
    !rail_on[0] |=> rail_good_indicator_oe[0])
    else $error("rail 1 good while off");
  a_all_needs_on: assert property (
    rail_on != 2'h3 |=> all_rails_good_oe)
    else $error("combined good while a rail is off");
  a_reset_state: assert property (disable iff (1'b0)
    srst |=> rail_on == 2'h0 && all_rails_good_oe)
    else $error("reset state wrong");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_slew_step: assert property (
    sat_low |-> dac_values[9:0] - $past(dac_values[9:0]) <= 10'h001)
    else $error("reference moved more than one step");
  a_slew_spacing: assert property (
    sat_low ##0 $changed(dac_values[9:0]) |-> gap >= STEP_GAP)
    else $error("reference slewed too fast");
endmodule // rail_ctrl_properties

// ---- tb/rail_sense_model.sv ----
// Purpose: rail output as seen at the differential sense pins
// Assumes: the rail settles on its reference at once
// Notes: return line wanders, so only the difference carries the level
`timescale 1ns/10ps
module rail_sense_model (
  input wire clk,
  input wire [9:0] dac,
  input wire signed [11:0] disturb,
  output logic signed [11:0] sense_positive,
  output logic signed [11:0] sense_negative
);
  logic [2:0] wander = 3'h0;
  always @(posedge clk) begin
    wander <= wander + 3'h1;
  end
  always @* begin
    sense_negative = {9'h000, wander};
    sense_positive = sense_negative + $signed({2'h0, dac}) + disturb;
  end
endmodule // rail_sense_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for rail_ctrl
// Assumes: 125 MHz clock, sense model tracks the reference
// Notes: expectations queued by the driver, compared at falling edges
`timescale 1ns/10ps
`include "rail_ctrl_consts.vh"
module testbench;
  logic clk, srst, wr, rd, bus_control_pin;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] rail_enable_pin, ramping, light_load, rail_in_window;
  logic [1:0] rail_on, fault_suppress, on, g;
  logic [1:0] rail_good_indicator_oe, rail_good_indicator_out;
  logic all_rails_good_oe, all_rails_good_out;
  logic [11:0] err_codes;
  logic [19:0] dac_values;
  logic signed [11:0] sense_positive_1, sense_negative_1;
  logic signed [11:0] sense_positive_2, sense_negative_2;
  logic signed [11:0] disturb1, disturb2;
  logic [9:0] sp [4];
  logic [9:0] d0;
  logic [5:0] e;
  logic [31:0] exp_q [$];
  logic [31:0] r;
  int kind_q [$];
  int errors = 0, comparisons = 0, cycles = 0, s, m, pol;
  rail_ctrl dut (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .bus_control_pin, .rail_enable_pin, .ramping, .light_load,
    .rail_in_window, .sense_positive_1, .sense_negative_1,
    .sense_positive_2, .sense_negative_2, .rail_on, .fault_suppress,
    .rail_good_indicator_oe, .rail_good_indicator_out,
    .all_rails_good_oe, .all_rails_good_out, .err_codes, .dac_values);
  rail_sense_model m1 (.clk, .dac(dac_values[9:0]), .disturb(disturb1),
    .sense_positive(sense_positive_1), .sense_negative(sense_negative_1));
  rail_sense_model m2 (.clk, .dac(dac_values[19:10]), .disturb(disturb2),
    .sense_positive(sense_positive_2), .sense_negative(sense_negative_2));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task note(input int k, input logic [31:0] v);
    kind_q.push_back(k);
    exp_q.push_back(v);
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [31:0] want);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    note(0, want);
  endtask
  function automatic logic [31:0] obs(input int k);
    case (k)
      0: obs = rdata;
      1: obs = {27'h0, all_rails_good_oe, rail_good_indicator_oe, rail_on};
      2: obs = {12'h0, dac_values};
      3: obs = {20'h0, err_codes};
      4: obs = {30'h0, fault_suppress};
      default: obs = {31'h0, dac_values[9:0] - d0 - 10'h2 <= 10'h1};
    endcase
  endfunction
  function automatic logic on_of(input logic [2:0] k, input logic p,
      input logic en, input logic run);
    case (k)
      `ONOFF_AUTO: on_of = 1'b1;
      `ONOFF_PIN: on_of = p & en;
      `ONOFF_CMD: on_of = run;
      `ONOFF_BOTH: on_of = p & en & run;
      default: on_of = 1'b0;
    endcase
  endfunction
  always @(negedge clk) begin
    while (exp_q.size() > 0)
      check(obs(kind_q.pop_front()), exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    {srst, wr, rd, addr, wdata, bus_control_pin} = {1'b1, 39'h0};
    {rail_enable_pin, ramping, light_load, rail_in_window} = 8'h00;
    {disturb1, disturb2} = 24'h0;
    void'($urandom(24902));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_reg(`REG_ON_OFF, 32'h49);
    rd_reg(`REG_GAIN_BANKS, 32'hAAA);
    wr_reg(4'hD, 32'hFFFF);
    rd_reg(4'hD, 32'h0);
    $display("test reset done");
    for (s = 0; s < 4; s++) begin
      // headroom so upward slewing never meets the DAC ceiling
      sp[s] = 10'($urandom_range(1000));
      wr_reg(4'h3 + s[3:0], {6'h0, sp[s], 6'h0, sp[s]});
    end
    for (s = 0; s < 4; s++) begin
      m = s == 3 ? 0 : s;
      wr_reg(`REG_VID_SETUP, s == 3 ? 32'h3 : 32'h0);
      wr_reg(`REG_OPERATION, {21'h0, m[1:0], 6'h9, m[1:0], 1'b1});
      repeat (300) @(posedge clk);
      note(2, {12'h0, sp[s], sp[s]});
      note(4, {31'h0, m != 0});
      rd_reg(`REG_DAC_R1, {22'h0, sp[s]});
      rd_reg(`REG_DAC_R2, {22'h0, sp[s]});
    end
    wr_reg(`REG_VID_SETUP, 32'h0);
    $display("test setpoint done");
    // sample point must stay below the period or no sample is taken
    r = $urandom_range(249);
    wr_reg(`REG_SAMPLE_POINT, r);
    rd_reg(`REG_SAMPLE_POINT, r);
    disturb1 <= 12'sd16;
    for (s = 0; s < 4; s++) begin
      wr_reg(`REG_GAIN_BANKS, {20'h0, 6'h2A, 2'h3, s[1:0], 2'h0});
      e = 6'h0 - (6'h2 << s);
      repeat (600) @(posedge clk);
      note(3, {26'h0, e});
    end
    light_load <= 2'h1;
    repeat (600) @(posedge clk);
    note(3, 32'h30);
    ramping <= 2'h1;
    repeat (600) @(posedge clk);
    note(3, 32'h3E);
    {ramping, light_load} <= 4'h0;
    disturb1 <= 12'sd64;
    disturb2 <= -12'sd80;
    repeat (600) @(posedge clk);
    note(3, 32'h7E0);
    @(negedge clk);
    d0 = dac_values[9:0];
    repeat (2000) @(posedge clk);
    note(5, 32'h1);
    {disturb1, disturb2} <= 24'h0;
    repeat (1000) @(posedge clk);
    note(3, 32'h0);
    note(2, {12'h0, sp[0], sp[0]});
    $display("test error path done");
    wr_reg(`REG_GOOD_CTRL, 32'h3);
    for (pol = 0; pol < 2; pol++)
      for (m = 0; m < 10; m++) begin
        s = (m / 2 + 2) % 5;
        wr_reg(`REG_ON_OFF, {25'h0, pol[0], s[2:0], 3'(m / 2)});
        r = $urandom;
        bus_control_pin <= r[0];
        rail_enable_pin <= r[2:1];
        rail_in_window <= r[4:3];
        wr_reg(`REG_OPERATION, {23'h0, r[5], 7'h0, r[6]});
        on[0] = on_of(3'(m / 2), r[0] == pol[0], r[1] == pol[0], r[6]);
        on[1] = on_of(s[2:0], r[0] == pol[0], r[2] == pol[0], r[5]);
        g = on & r[4:3];
        repeat (6) @(posedge clk);
        note(1, {27'h0, ~&g, ~g, on});
        rd_reg(`REG_STATUS, {28'h0, ~g, on});
      end
    $display("test on off done");
    @(posedge clk);
    test_done;
  end
endmodule // testbench
bind rail_ctrl rail_ctrl_properties chk (.clk, .srst, .rd, .rdata,
  .rail_on, .rail_good_indicator_oe, .rail_good_indicator_out,
  .all_rails_good_oe, .all_rails_good_out, .err_codes, .dac_values);
